// File: shared/clk_select_consts.vh
// Offsets, config word fields, codes and reset values of the clock source selector
`ifndef CLK_SELECT_CONSTS_VH
`define CLK_SELECT_CONSTS_VH

`define OFF_STATUS      8'h00
`define OFF_SWITCH      8'h04
`define OFF_FLAGS       8'h08
`define OFF_POSTDIV     8'h0c
`define OFF_CONFIG      8'h10

`define CW_MODE_MSB     1
`define CW_MODE_LSB     0
`define CW_OUTFN_BIT    5
`define CW_SWMON_MSB    7
`define CW_SWMON_LSB    6
`define CW_SEL_MSB      10
`define CW_SEL_LSB      8
`define CW_ERASED       16'hffff

`define SEL_FAST_RC     3'h0
`define SEL_FAST_RC_PLL 3'h1
`define SEL_PRIMARY     3'h2
`define SEL_PRIMARY_PLL 3'h3
`define SEL_SECONDARY   3'h4
`define SEL_LOW_POWER   3'h5
`define SEL_RESERVED    3'h6
`define SEL_FAST_RC_DIV 3'h7

`define MODE_EXT_CLK    2'h0
`define MODE_CRYSTAL    2'h1
`define MODE_HIGH_SPEED 2'h2
`define MODE_PRI_OFF    2'h3

`define SWMON_MONITOR   2'h0

`define SRC_FAST_RC     2'h0
`define SRC_PRIMARY     2'h1
`define SRC_SECONDARY   2'h2
`define SRC_LOW_POWER   2'h3

`define ST_SEL_LSB      0
`define ST_MODE_LSB     3
`define ST_SW_BIT       5
`define ST_MON_BIT      6
`define ST_PLL_BIT      7
`define ST_POST_BIT     8
`define ST_UNSUP_BIT    9
`define ST_PINIO_BIT    10
`define ST_SRC_LSB      11
`define ST_BUSY_BIT     13

`define FLAG_REJECT_BIT 0
`define FLAG_DONE_BIT   1
`define FLAG_FAIL_BIT   2

`define POSTDIV_RST     3'h1

`endif

// File: design/osc_mode_decode.v
// Maps a select/mode pair onto a source, PLL and postscaler use and pin function
`timescale 1ns/1ps
`include "clk_select_consts.vh"

module osc_mode_decode
(
	input  wire [2:0] sel_i,
	input  wire [1:0] mode_i,
	input  wire       outfn_i,
	output reg  [1:0] src_o,
	output reg        pll_o,
	output reg        post_o,
	output reg        pin_io_o,
	output reg        ok_o
);

	always @*
	begin
		src_o    = `SRC_FAST_RC;
		pll_o    = 1'b0;
		post_o   = 1'b0;
		pin_io_o = outfn_i;
		ok_o     = 1'b1;
		case (sel_i)
			`SEL_FAST_RC: ;
			`SEL_FAST_RC_PLL: pll_o = 1'b1;
			`SEL_PRIMARY:
			begin
				if (mode_i == `MODE_PRI_OFF)
					ok_o = 1'b0;
				else
				begin
					src_o = `SRC_PRIMARY;
					// Crystal amplifiers own the output pin
					if (mode_i != `MODE_EXT_CLK)
						pin_io_o = 1'b0;
				end
			end
			`SEL_PRIMARY_PLL:
			begin
				if (mode_i == `MODE_CRYSTAL || mode_i == `MODE_EXT_CLK)
				begin
					src_o = `SRC_PRIMARY;
					pll_o = 1'b1;
					if (mode_i == `MODE_CRYSTAL)
						pin_io_o = 1'b0;
				end
				else
					ok_o = 1'b0;
			end
			`SEL_SECONDARY: src_o = `SRC_SECONDARY;
			`SEL_LOW_POWER: src_o = `SRC_LOW_POWER;
			`SEL_FAST_RC_DIV: post_o = 1'b1;
			default: ok_o = 1'b0;
		endcase
		// Unsupported pairs fall back to the plain fast RC
		if (!ok_o)
		begin
			src_o    = `SRC_FAST_RC;
			pll_o    = 1'b0;
			post_o   = 1'b0;
			pin_io_o = outfn_i;
		end
	end

endmodule // osc_mode_decode

// File: design/postscale_divider.v
// Postscaler: one-cycle enable every 2^n cycles, or every cycle when bypassed
`timescale 1ns/1ps

module postscale_divider
#(
	parameter EXP_W = 3,
	parameter CNT_W = 8
)
(
	input  wire             clk_i,
	input  wire             resetn_i,
	input  wire             enable_i,
	input  wire [EXP_W-1:0] div_exp_i,
	output reg              tick_o
);

	reg  [CNT_W-1:0] count_reg;
	wire [CNT_W-1:0] last_count;

	assign last_count = ({{(CNT_W-1){1'b0}}, 1'b1} << div_exp_i) - {{(CNT_W-1){1'b0}}, 1'b1};

	always @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			count_reg <= {CNT_W{1'b0}};
			tick_o    <= 1'b0;
		end
		else if (!enable_i)
		begin
			count_reg <= {CNT_W{1'b0}};
			tick_o    <= 1'b1;
		end
		// A shrunken divide value past the count restarts at once
		else if (count_reg >= last_count)
		begin
			count_reg <= {CNT_W{1'b0}};
			tick_o    <= 1'b1;
		end
		else
		begin
			count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			tick_o    <= 1'b0;
		end
	end

endmodule // postscale_divider

// File: design/clk_source_select.v
// Power-on clock source selection, switch gating and fail-safe fallback
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "clk_select_consts.vh"

module clk_source_select
#(
	parameter ADDR_W = 8,
	parameter DATA_W = 16,
	parameter CNT_W  = 8
)
(
	input  wire              clk_i,
	input  wire              resetn_i,
	input  wire [15:0]       cfg_word_i,
	input  wire              osc_fail_i,
	input  wire [ADDR_W-1:0] addr_i,
	input  wire [DATA_W-1:0] wdata_i,
	input  wire              wr_i,
	input  wire              rd_i,
	output reg  [DATA_W-1:0] rdata_o,
	output reg  [2:0]        active_sel_o,
	output reg  [1:0]        osc_source_o,
	output reg  [1:0]        primary_mode_o,
	output reg               pll_en_o,
	output reg               postscaler_en_o,
	output reg               sys_clk_en_o,
	output reg               osc_pin_io_o,
	output reg               switch_allowed_o,
	output reg               monitor_en_o,
	output reg               sel_unsupported_o
);

	localparam ST_LOAD   = 2'h0;
	localparam ST_RUN    = 2'h1;
	localparam ST_SWITCH = 2'h2;

	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [15:0] cfg_reg;
	reg  [2:0]  sel_reg;
	reg  [2:0]  sel_next;
	reg  [2:0]  pend_reg;
	reg  [2:0]  postdiv_reg;
	reg  [2:0]  flags_reg;
	reg  [2:0]  flags_next;
	reg  [DATA_W-1:0] rd_mux;

	wire [1:0]  cfg_mode;
	wire        cfg_outfn;
	wire [1:0]  cfg_swmon;
	wire        sw_allowed;
	wire        mon_en;
	wire [1:0]  dec_src;
	wire        dec_pll;
	wire        dec_post;
	wire        dec_pin_io;
	wire        dec_ok;
	wire        req_ok;
	wire        div_tick;
	wire        wr_switch;
	wire        wr_flags;
	wire        wr_postdiv;
	wire        fail_hit;
	wire        sw_accept;
	wire        sw_reject;

	// Mode, pin and switch fields come from the latched copy; the select field is taken raw at load
	assign cfg_mode   = cfg_reg[`CW_MODE_MSB:`CW_MODE_LSB];
	assign cfg_outfn  = cfg_reg[`CW_OUTFN_BIT];
	assign cfg_swmon  = cfg_reg[`CW_SWMON_MSB:`CW_SWMON_LSB];
	assign sw_allowed = ~cfg_swmon[1];
	assign mon_en     = (cfg_swmon == `SWMON_MONITOR);

	osc_mode_decode u_active_decode
	(
		.sel_i    (sel_reg),
		.mode_i   (cfg_mode),
		.outfn_i  (cfg_outfn),
		.src_o    (dec_src),
		.pll_o    (dec_pll),
		.post_o   (dec_post),
		.pin_io_o (dec_pin_io),
		.ok_o     (dec_ok)
	);

	// Same table screens a requested switch before it is taken
	osc_mode_decode u_request_decode
	(
		.sel_i    (wdata_i[2:0]),
		.mode_i   (cfg_mode),
		.outfn_i  (cfg_outfn),
		.src_o    (),
		.pll_o    (),
		.post_o   (),
		.pin_io_o (),
		.ok_o     (req_ok)
	);

	postscale_divider
	#(
		.EXP_W (3),
		.CNT_W (CNT_W)
	)
	u_postscaler
	(
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.enable_i  (dec_post),
		.div_exp_i (postdiv_reg),
		.tick_o    (div_tick)
	);

	assign wr_switch  = wr_i && (addr_i == `OFF_SWITCH);
	assign wr_flags   = wr_i && (addr_i == `OFF_FLAGS);
	assign wr_postdiv = wr_i && (addr_i == `OFF_POSTDIV);

	// Fallback on a failed source wins over a pending switch
	assign fail_hit  = (state_reg != ST_LOAD) && mon_en && osc_fail_i
		&& (dec_src != `SRC_FAST_RC);
	assign sw_accept = (state_reg == ST_RUN) && wr_switch && sw_allowed
		&& req_ok && !fail_hit;
	assign sw_reject = wr_switch && !sw_accept && !fail_hit;

	always @*
	begin
		state_next = state_reg;
		sel_next   = sel_reg;
		case (state_reg)
			ST_LOAD:
			begin
				sel_next   = cfg_word_i[`CW_SEL_MSB:`CW_SEL_LSB];
				state_next = ST_RUN;
			end
			ST_RUN:
			begin
				if (fail_hit)
					sel_next = `SEL_FAST_RC;
				else if (sw_accept)
					state_next = ST_SWITCH;
			end
			ST_SWITCH:
			begin
				if (fail_hit)
					sel_next = `SEL_FAST_RC;
				else
					sel_next = pend_reg;
				state_next = ST_RUN;
			end
			default:
			begin
				state_next = ST_LOAD;
			end
		endcase
	end

	// Hardware sets win over a write-one-to-clear in the same cycle
	always @*
	begin
		flags_next = flags_reg;
		if (wr_flags)
			flags_next = flags_reg & ~wdata_i[2:0];
		if (sw_reject)
			flags_next[`FLAG_REJECT_BIT] = 1'b1;
		if (state_reg == ST_SWITCH && !fail_hit)
			flags_next[`FLAG_DONE_BIT] = 1'b1;
		if (fail_hit)
			flags_next[`FLAG_FAIL_BIT] = 1'b1;
	end

	always @*
	begin
		rd_mux = {DATA_W{1'b0}};
		case (addr_i)
			`OFF_STATUS:
			begin
				rd_mux[`ST_SEL_LSB +: 3]  = sel_reg;
				rd_mux[`ST_MODE_LSB +: 2] = cfg_mode;
				rd_mux[`ST_SW_BIT]        = sw_allowed;
				rd_mux[`ST_MON_BIT]       = mon_en;
				rd_mux[`ST_PLL_BIT]       = dec_pll;
				rd_mux[`ST_POST_BIT]      = dec_post;
				rd_mux[`ST_UNSUP_BIT]     = ~dec_ok;
				rd_mux[`ST_PINIO_BIT]     = dec_pin_io;
				rd_mux[`ST_SRC_LSB +: 2]  = dec_src;
				rd_mux[`ST_BUSY_BIT]      = (state_reg != ST_RUN);
			end
			`OFF_SWITCH:  rd_mux[2:0] = pend_reg;
			`OFF_FLAGS:   rd_mux[2:0] = flags_reg;
			`OFF_POSTDIV: rd_mux[2:0] = postdiv_reg;
			`OFF_CONFIG:  rd_mux[15:0] = cfg_reg;
			default:      rd_mux = {DATA_W{1'b0}};
		endcase
	end

	always @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			state_reg   <= ST_LOAD;
			cfg_reg     <= `CW_ERASED;
			sel_reg     <= `SEL_FAST_RC_DIV;
			pend_reg    <= `SEL_FAST_RC_DIV;
			postdiv_reg <= `POSTDIV_RST;
			flags_reg   <= 3'h0;
			rdata_o     <= {DATA_W{1'b0}};
		end
		else
		begin
			state_reg <= state_next;
			sel_reg   <= sel_next;
			flags_reg <= flags_next;
			// Caught once, one edge after release; later changes are ignored
			if (state_reg == ST_LOAD)
				cfg_reg <= cfg_word_i;
			if (sw_accept)
				pend_reg <= wdata_i[2:0];
			if (wr_postdiv)
				postdiv_reg <= wdata_i[2:0];
			if (rd_i)
				rdata_o <= rd_mux;
			else
				rdata_o <= {DATA_W{1'b0}};
		end
	end

	// Every output is a flop; they trail the decode by one cycle, sys_clk_en_o by two
	always @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			active_sel_o      <= `SEL_FAST_RC_DIV;
			osc_source_o      <= `SRC_FAST_RC;
			primary_mode_o    <= `MODE_PRI_OFF;
			pll_en_o          <= 1'b0;
			postscaler_en_o   <= 1'b1;
			sys_clk_en_o      <= 1'b0;
			osc_pin_io_o      <= 1'b1;
			switch_allowed_o  <= 1'b0;
			monitor_en_o      <= 1'b0;
			sel_unsupported_o <= 1'b0;
		end
		else
		begin
			active_sel_o      <= sel_reg;
			osc_source_o      <= dec_src;
			primary_mode_o    <= cfg_mode;
			pll_en_o          <= dec_pll;
			postscaler_en_o   <= dec_post;
			sys_clk_en_o      <= div_tick;
			osc_pin_io_o      <= dec_pin_io;
			switch_allowed_o  <= sw_allowed;
			monitor_en_o      <= mon_en;
			sel_unsupported_o <= ~dec_ok;
		end
	end

endmodule // clk_source_select

// File: sim/clk_select_monitor.sv
// Port-level assertions for the clock source selector
`timescale 1ns/1ps
`include "clk_select_consts.vh"
module clk_select_monitor
#(
	parameter ADDR_W = 8,
	parameter DATA_W = 16
)
(
	input wire              clk_i,
	input wire              resetn_i,
	input wire [15:0]       cfg_word_i,
	input wire              osc_fail_i,
	input wire [ADDR_W-1:0] addr_i,
	input wire [DATA_W-1:0] wdata_i,
	input wire              wr_i,
	input wire              rd_i,
	input wire [DATA_W-1:0] rdata_o,
	input wire [2:0]        active_sel_o,
	input wire [1:0]        osc_source_o,
	input wire              pll_en_o,
	input wire              postscaler_en_o,
	input wire              sys_clk_en_o,
	input wire              switch_allowed_o,
	input wire              monitor_en_o,
	input wire              sel_unsupported_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Cycles since release; outputs are valid from two on
	reg [1:0] up;
	always @(posedge clk_i)
		if (!resetn_i)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	sequence sw_req;
		wr_i && addr_i == `OFF_SWITCH && switch_allowed_o && up[1] && !$past(wr_i)
			&& !osc_fail_i && !wdata_i[1];
	endsequence
	sequence quiet3;
		(!wr_i && !osc_fail_i)[*3];
	endsequence
	chk_gate_switch: assert property (up[1] |-> switch_allowed_o == !cfg_word_i[7])
		else $error("switch gate wrong");
	chk_gate_monitor: assert property (up[1] |-> monitor_en_o == (cfg_word_i[7:6] == 2'h0))
		else $error("monitor gate wrong");
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 0)
		else $error("read data outside its cycle");
	chk_postdiv_sel: assert property (postscaler_en_o |-> active_sel_o == 3'h7 && !pll_en_o)
		else $error("postscaler without select 111");
	chk_full_rate: assert property (up[1] && !postscaler_en_o && !$past(postscaler_en_o) |-> sys_clk_en_o)
		else $error("clock enable gap without postscaler");
	chk_unsup_fallback: assert property (sel_unsupported_o |-> osc_source_o == `SRC_FAST_RC && !pll_en_o)
		else $error("unsupported pair not on fast RC");
	chk_slow_sources: assert property (active_sel_o[2:1] == 2'h2 |-> osc_source_o == {1'b1, active_sel_o[0]})
		else $error("slow source mismatch");
	chk_fail_fallback: assert property (monitor_en_o && osc_fail_i && osc_source_o != `SRC_FAST_RC && !$past(wr_i)
		|-> ##2 osc_source_o == `SRC_FAST_RC && active_sel_o == `SEL_FAST_RC)
		else $error("no fallback after failure");
	chk_switch_take: assert property (sw_req |-> ##3 {13'h0, active_sel_o} == ($past(wdata_i, 3) & 16'h0007))
		else $error("accepted switch not applied");
	chk_hold_quiet: assert property (up[1] ##0 quiet3 |=> $stable(active_sel_o))
		else $error("selection moved without cause");
	chk_refused_hold: assert property (wr_i && addr_i == `OFF_SWITCH && up[1] && !switch_allowed_o
		|=> $stable(active_sel_o)[*3])
		else $error("refused switch changed selection");
endmodule // clk_select_monitor

bind clk_source_select clk_select_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon
(
	.clk_i(clk_i), .resetn_i(resetn_i), .cfg_word_i(cfg_word_i), .osc_fail_i(osc_fail_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.active_sel_o(active_sel_o), .osc_source_o(osc_source_o), .pll_en_o(pll_en_o),
	.postscaler_en_o(postscaler_en_o), .sys_clk_en_o(sys_clk_en_o),
	.switch_allowed_o(switch_allowed_o), .monitor_en_o(monitor_en_o),
	.sel_unsupported_o(sel_unsupported_o)
);

// File: sim/osc_sources_model.sv
// Oscillator sources: flags a failure while a killed source is selected
`timescale 1ns/1ps
`include "clk_select_consts.vh"
module osc_sources_model
(
	input  wire       clk_i,
	input  wire [1:0] source_i,
	input  wire [3:0] dead_i,
	output reg        osc_fail_o
);
	initial osc_fail_o = 1'b0;
	// Fast RC never dies, so the fallback target always runs
	always @(posedge clk_i)
		osc_fail_o <= dead_i[source_i] && source_i != `SRC_FAST_RC;
endmodule // osc_sources_model

// File: sim/testbench.sv
// Self-checking bench for the clock source selector
`timescale 1ns/1ps
`include "clk_select_consts.vh"
module testbench;
	reg         clk, rst_n, wr, rd, fn;
	reg  [15:0] cfg, wdata;
	reg  [7:0]  addr;
	reg  [3:0]  dead;
	reg  [10:0] e;
	reg  [1:0]  sm;
	wire [15:0] rdata;
	wire [2:0]  asel;
	wire [1:0]  src, pmode;
	wire        pll, post, sclk, pin, swa, mon, uns, fail;
	integer     error_cnt, total_checks, i;
	// Per entry: select, mode, source, pll, postscaler, unsupported, pin owned
	localparam [153:0] TBL = {11'h7c4, 11'h6c2, 11'h5f0, 11'h4e0, 11'h359, 11'h318, 11'h291,
		11'h251, 11'h210, 11'h1c8, 11'h0c0, 11'h382, 11'h2c2, 11'h602};
	clk_source_select dut (.clk_i(clk), .resetn_i(rst_n), .cfg_word_i(cfg), .osc_fail_i(fail),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.active_sel_o(asel), .osc_source_o(src), .primary_mode_o(pmode), .pll_en_o(pll),
		.postscaler_en_o(post), .sys_clk_en_o(sclk), .osc_pin_io_o(pin),
		.switch_allowed_o(swa), .monitor_en_o(mon), .sel_unsupported_o(uns));
	osc_sources_model u_osc (.clk_i(clk), .source_i(src), .dead_i(dead), .osc_fail_o(fail));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task conclude;
	begin
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	task chk(input string nm, input [15:0] x, input [15:0] g);
	begin
		total_checks = total_checks + 1;
		if (g !== x)
		begin
			error_cnt = error_cnt + 1;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	end
	endtask
	task idle(input integer n);
	begin
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	end
	endtask
	task rst(input [15:0] c);
	begin
		rst_n <= 1'b0;
		cfg <= c;
		idle(16);
		rst_n <= 1'b1;
		idle(3);
	end
	endtask
	task wrt(input [7:0] a, input [15:0] d);
	begin
		addr <= a;
		wdata <= d;
		rd <= 1'b0;
		wr <= 1'b1;
		@(posedge clk);
	end
	endtask
	task rdc(input string nm, input [7:0] a, input [15:0] x);
	begin
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, x, rdata);
	end
	endtask
	task pulses(input [15:0] x);
		integer k, n;
	begin
		n = 0;
		for (k = 0; k < 16; k = k + 1)
		begin
			@(posedge clk);
			#1;
			if (sclk === 1'b1)
				n = n + 1;
		end
		chk("clock enables", x, n[15:0]);
	end
	endtask
	initial
	begin
		#300000;
		error_cnt = error_cnt + 1;
		conclude;
	end
	initial
	begin
		{rst_n, wr, rd, fn, cfg, wdata, addr, dead, e, sm} = 0;
		error_cnt = 0;
		total_checks = 0;
		rst(16'hffff);
		chk("erased", 16'h01c4, {asel, src, pll, post, swa, mon});
		rdc("config", `OFF_CONFIG, 16'hffff);
		rdc("postdiv", `OFF_POSTDIV, 16'h0001);
		pulses(16'h0008);
		wrt(`OFF_POSTDIV, 16'h0002);
		idle(16);
		pulses(16'h0004);
		wrt(`OFF_SWITCH, 16'h0000);
		wrt(8'h20, 16'hffff);
		idle(3);
		rdc("refused flag", `OFF_FLAGS, 16'h0001);
		rdc("unmapped", 8'h20, 16'h0000);
		chk("kept select", 16'h0007, asel);
		$display("test erased done");
		for (i = 0; i < 14; i = i + 1)
		begin
			e = TBL[i*11 +: 11];
			sm = i[1:0];
			fn = i[2];
			rst({5'h1f, e[10:8], sm, fn, 3'h7, e[7:6]});
			chk("decode", {e[10:1], e[0] ? 1'b0 : fn, ~sm[1], sm == 2'h0},
				{asel, pmode, src, pll, post, uns, pin, swa, mon});
		end
		$display("test decode done");
		rst(16'h0063);
		pulses(16'h0010);
		wrt(`OFF_SWITCH, 16'h0005);
		idle(3);
		chk("to low power", 16'h0017, {asel, src});
		rdc("status", `OFF_STATUS, 16'h1c3d);
		rdc("switch reg", `OFF_SWITCH, 16'h0005);
		wrt(`OFF_SWITCH, 16'h0004);
		wrt(`OFF_SWITCH, 16'h0001);
		idle(4);
		chk("to secondary", 16'h0012, {asel, src});
		rdc("busy flags", `OFF_FLAGS, 16'h0003);
		wrt(`OFF_FLAGS, 16'h0003);
		idle(2);
		rdc("cleared", `OFF_FLAGS, 16'h0000);
		wrt(`OFF_SWITCH, 16'h0006);
		dead <= 4'h4;
		idle(4);
		chk("reserved or fail", 16'h0012, {asel, src});
		rdc("reserved flag", `OFF_FLAGS, 16'h0001);
		dead <= 4'h0;
		wrt(`OFF_SWITCH, 16'h0007);
		idle(4);
		chk("to postscaler", 16'h0001, {src, post});
		$display("test switch done");
		rst(16'h0201);
		dead <= 4'h2;
		idle(4);
		chk("fallback", 16'h0000, {asel, src});
		rdc("fail flag", `OFF_FLAGS, 16'h0004);
		dead <= 4'h0;
		$display("test monitor done");
		conclude;
	end
endmodule // testbench
